/* include/cie_consts.vh */
`ifndef CIE_CONSTS_VH
`define CIE_CONSTS_VH

// Source count and which sources follow a condition level
`define CIE_NSRC 8
`define CIE_IDXW 3
`define CIE_LEVEL_MASK 8'hf0

// Register offsets on the plain register port
`define CIE_ADDR_FLAGS 3'h0
`define CIE_ADDR_ENABLE 3'h1
`define CIE_ADDR_STATUS 3'h2
`define CIE_ADDR_SPL 3'h3
`define CIE_ADDR_SPH 3'h4
`define CIE_ADDR_INFO 3'h5

// Field positions and reset values
`define CIE_GIE_BIT 7
`define CIE_STATUS_RST 8'h00
`define CIE_SP_RST 16'h0000
`define CIE_ENABLE_RST 8'h00

// Vector placement, in program words
`define CIE_RESET_VEC 15'h0000
`define CIE_BOOT_START 15'h3800
`define CIE_VEC_STEP 15'h0002

// Timing counts in clock cycles
`define CIE_RESP_CYC 3'h4
`define CIE_JUMP_CYC 3'h3
`define CIE_WAKE_CYC 3'h4
`define CIE_RETURN_FROM_HANDLER_INSTR_CYC 3'h4
`define CIE_BOOT_CYC 3'h4

`endif

/* verilog/cie_prio.v */
`timescale 1ns/1ps
`include "cie_consts.vh"

module cie_prio
(
  // Pending requests, bit 0 highest priority
  input wire [`CIE_NSRC-1:0] req_i,
  // Winner
  output reg any_o,
  output reg [`CIE_IDXW-1:0] idx_o
);

  wire [`CIE_NSRC-1:0] higher;

  // A bit sees a request above it when any lower index is asking
  genvar g;
  generate
    for (g = 0; g < `CIE_NSRC; g = g + 1)
    begin : g_chain
      if (g == 0)
      begin : g_first
        assign higher[g] = 1'b0;
      end
      else
      begin : g_rest
        assign higher[g] = higher[g-1] | req_i[g-1];
      end
    end
  endgenerate

  integer i;
  always @*
  begin
    any_o = |req_i;
    idx_o = {`CIE_IDXW{1'b0}};
    for (i = 0; i < `CIE_NSRC; i = i + 1)
      if (req_i[i] && !higher[i])
        idx_o = i[`CIE_IDXW-1:0];
  end

endmodule

/* verilog/cie_ctrl.v */
`timescale 1ns/1ps
`include "cie_consts.vh"

// How it works
// - Taking an interrupt clears global enable
// - Handler setting enable allows nested interrupts
// - Return instruction sets global enable
// - Vectoring clears that source's pending flag
// - Writing one clears flag, zero keeps
// - Flags latch while global enable is off
// - Level sources request only while present
// - One main instruction runs after return
// - Disable instruction blocks same-cycle requests
// - Instruction after enable runs before interrupt
// - Response four cycles, pushing program counter
// - Vector jump takes three cycles
// - Multi-cycle instruction finishes before response
// - Wake from sleep adds four cycles
// - Return pops two bytes in four cycles
// - Boot fuse moves reset vector
// - Needs own enable and global enable
// - Lower vector index wins priority
// - Entry push lowers stack pointer by two
module cie_ctrl
(
  // Clock and reset
  input wire clk_i,
  input wire reset_i,
  // Register port
  input wire [2:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  // Interrupt sources
  input wire [`CIE_NSRC-1:0] src_i,
  // Instruction pipeline
  input wire instr_done_i,
  input wire instr_cli_i,
  input wire instr_sei_i,
  input wire instr_return_from_handler_instr_i,
  input wire [14:0] program_counter_i,
  input wire sleeping_i,
  input wire wake_ready_i,
  output reg cpu_hold_o,
  output reg pc_load_o,
  output reg [14:0] pc_value_o,
  output reg vector_jump_o,
  // Stack memory
  output reg stack_wr_o,
  output reg stack_rd_o,
  output reg [15:0] stack_addr_o,
  output reg [7:0] stack_wdata_o,
  input wire [7:0] stack_rdata_i,
  // Fuse pin
  input wire boot_reset_vector_fuse_i,
  // Status
  output reg gie_o
);

  localparam ST_BOOT = 3'h0;
  localparam ST_IDLE = 3'h1;
  localparam ST_SLEEPW = 3'h2;
  localparam ST_WAKE = 3'h3;
  localparam ST_RESP = 3'h4;
  localparam ST_JUMP = 3'h5;
  localparam ST_RETURN_FROM_HANDLER_INSTR = 3'h6;

  reg [2:0] state;
  reg [2:0] cnt;
  reg [7:0] flags;
  reg [7:0] enable;
  reg [7:0] status_word;
  reg [15:0] sp;
  reg [14:0] ret_pc;
  reg [`CIE_IDXW-1:0] act_idx;
  reg [7:0] ret_hi;
  reg fuse_s1;
  reg fuse_s2;
  reg fuse_s3;
  reg fuse_q;

  reg [7:0] next_flags;
  reg [7:0] sw_clr;
  reg [7:0] hw_clr;
  reg [7:0] pending;
  reg take;
  reg take_sleep;

  wire win_any;
  wire [`CIE_IDXW-1:0] win_idx;
  wire gie;
  wire [14:0] vec_addr;
  wire [14:0] boot_vec;

  assign gie = status_word[`CIE_GIE_BIT];
  // Vector n sits n+1 jump slots after the reset vector slot
  assign vec_addr = `CIE_VEC_STEP
    + {{(15-`CIE_IDXW){1'b0}}, act_idx} * `CIE_VEC_STEP;
  assign boot_vec = fuse_q ? `CIE_BOOT_START : `CIE_RESET_VEC;

  cie_prio u_prio
  (
    .req_i(pending),
    .any_o(win_any),
    .idx_o(win_idx)
  );

  always @*
  begin
    // Flag sources only latch; level sources bypass the flag
    pending = ((flags & ~`CIE_LEVEL_MASK)
      | (src_i & `CIE_LEVEL_MASK)) & enable;
    sw_clr = 8'h00;
    if (reg_wr_i && reg_addr_i == `CIE_ADDR_FLAGS)
      sw_clr = reg_wdata_i & ~`CIE_LEVEL_MASK;
    hw_clr = 8'h00;
    if (state == ST_RESP && cnt == 3'h3)
      hw_clr = 8'h01 << act_idx;
    // A new event beats any clear in the same cycle
    next_flags = (flags & ~sw_clr & ~hw_clr)
      | (src_i & ~`CIE_LEVEL_MASK);
    // Taken only at an instruction boundary or in sleep, never on the
    // boundary of a disable, enable or return instruction
    take = state == ST_IDLE && instr_done_i && gie
      && !instr_cli_i && !instr_sei_i && !instr_return_from_handler_instr_i
      && win_any;
    take_sleep = state == ST_IDLE && sleeping_i && !instr_done_i
      && gie && win_any;
  end

  // Fuse pin is asynchronous to the core clock; the chain keeps
  // running through reset so the boot vector sees a settled fuse
  always @(posedge clk_i)
  begin
    fuse_s1 <= boot_reset_vector_fuse_i;
    fuse_s2 <= fuse_s1;
    fuse_s3 <= fuse_s2;
    if (fuse_s2 == fuse_s3)
      fuse_q <= fuse_s3;
  end

  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state <= ST_BOOT;
      cnt <= 3'h0;
      flags <= 8'h00;
      enable <= `CIE_ENABLE_RST;
      status_word <= `CIE_STATUS_RST;
      sp <= `CIE_SP_RST;
      ret_pc <= 15'h0000;
      act_idx <= {`CIE_IDXW{1'b0}};
      ret_hi <= 8'h00;
      reg_rdata_o <= 8'h00;
      cpu_hold_o <= 1'b1;
      pc_load_o <= 1'b0;
      pc_value_o <= 15'h0000;
      vector_jump_o <= 1'b0;
      stack_wr_o <= 1'b0;
      stack_rd_o <= 1'b0;
      stack_addr_o <= 16'h0000;
      stack_wdata_o <= 8'h00;
      gie_o <= 1'b0;
    end
    else
    begin
      pc_load_o <= 1'b0;
      stack_wr_o <= 1'b0;
      stack_rd_o <= 1'b0;
      flags <= next_flags;

      // Software side; hardware updates below take precedence
      reg_rdata_o <= 8'h00;
      if (reg_rd_i)
      begin
        case (reg_addr_i)
          `CIE_ADDR_FLAGS: reg_rdata_o <= flags;
          `CIE_ADDR_ENABLE: reg_rdata_o <= enable;
          `CIE_ADDR_STATUS: reg_rdata_o <= status_word;
          `CIE_ADDR_SPL: reg_rdata_o <= sp[7:0];
          `CIE_ADDR_SPH: reg_rdata_o <= sp[15:8];
          `CIE_ADDR_INFO: reg_rdata_o <= {win_any, state,
            {(4-`CIE_IDXW){1'b0}}, act_idx};
          default: reg_rdata_o <= 8'h00;
        endcase
      end
      if (reg_wr_i)
      begin
        case (reg_addr_i)
          `CIE_ADDR_ENABLE: enable <= reg_wdata_i;
          // Whole word is software's; entry never saves it
          `CIE_ADDR_STATUS: status_word <= reg_wdata_i;
          `CIE_ADDR_SPL: sp[7:0] <= reg_wdata_i;
          `CIE_ADDR_SPH: sp[15:8] <= reg_wdata_i;
          default: sp <= sp;
        endcase
      end
      if (instr_done_i && instr_cli_i)
        status_word[`CIE_GIE_BIT] <= 1'b0;
      if (instr_done_i && instr_sei_i)
        status_word[`CIE_GIE_BIT] <= 1'b1;

      case (state)
        ST_BOOT:
        begin
          // Gives the fuse synchroniser time to settle
          cnt <= cnt + 3'h1;
          if (cnt == `CIE_BOOT_CYC - 3'h1)
          begin
            cnt <= 3'h0;
            pc_load_o <= 1'b1;
            pc_value_o <= boot_vec;
            cpu_hold_o <= 1'b0;
            state <= ST_IDLE;
          end
        end
        ST_IDLE:
        begin
          cnt <= 3'h0;
          if (take || take_sleep)
          begin
            act_idx <= win_idx;
            ret_pc <= program_counter_i;
            status_word[`CIE_GIE_BIT] <= 1'b0;
            cpu_hold_o <= 1'b1;
            state <= take ? ST_RESP : ST_SLEEPW;
          end
          else if (instr_done_i && instr_return_from_handler_instr_i)
          begin
            cpu_hold_o <= 1'b1;
            stack_rd_o <= 1'b1;
            stack_addr_o <= sp + 16'h0001;
            state <= ST_RETURN_FROM_HANDLER_INSTR;
          end
        end
        ST_SLEEPW:
        begin
          if (wake_ready_i)
            state <= ST_WAKE;
        end
        ST_WAKE:
        begin
          cnt <= cnt + 3'h1;
          if (cnt == `CIE_WAKE_CYC - 3'h1)
          begin
            cnt <= 3'h0;
            state <= ST_RESP;
          end
        end
        ST_RESP:
        begin
          cnt <= cnt + 3'h1;
          case (cnt)
            3'h0:
            begin
              stack_wr_o <= 1'b1;
              stack_addr_o <= sp;
              stack_wdata_o <= ret_pc[7:0];
            end
            3'h1:
            begin
              stack_wr_o <= 1'b1;
              stack_addr_o <= sp - 16'h0001;
              stack_wdata_o <= {1'b0, ret_pc[14:8]};
            end
            3'h2: sp <= sp - 16'h0002;
            default:
            begin
              pc_load_o <= 1'b1;
              pc_value_o <= vec_addr;
              cpu_hold_o <= 1'b0;
              vector_jump_o <= 1'b1;
              cnt <= 3'h0;
              state <= ST_JUMP;
            end
          endcase
        end
        ST_JUMP:
        begin
          // Core runs the vector jump; nothing new is taken
          cnt <= cnt + 3'h1;
          if (cnt == `CIE_JUMP_CYC - 3'h1)
          begin
            vector_jump_o <= 1'b0;
            cnt <= 3'h0;
            state <= ST_IDLE;
          end
        end
        ST_RETURN_FROM_HANDLER_INSTR:
        begin
          cnt <= cnt + 3'h1;
          case (cnt)
            3'h0:
            begin
              stack_rd_o <= 1'b1;
              stack_addr_o <= sp + 16'h0002;
            end
            3'h1: ret_hi <= stack_rdata_i;
            3'h2:
            begin
              pc_value_o <= {ret_hi[6:0], stack_rdata_i};
              sp <= sp + 16'h0002;
            end
            default:
            begin
              pc_load_o <= 1'b1;
              status_word[`CIE_GIE_BIT] <= 1'b1;
              cpu_hold_o <= 1'b0;
              cnt <= 3'h0;
              state <= ST_IDLE;
            end
          endcase
        end
        default: state <= ST_IDLE;
      endcase
      gie_o <= gie;
    end
  end

endmodule

/* testbench/cie_monitor.sv */
`timescale 1ns/1ps
module cie_monitor
(
  // Clock and reset
  input wire clk_i,
  input wire reset_i,
  // Pipeline
  input wire instr_done_i,
  input wire instr_cli_i,
  input wire instr_sei_i,
  input wire instr_return_from_handler_instr_i,
  input wire wake_ready_i,
  input wire boot_reset_vector_fuse_i,
  // Controller outputs
  input wire cpu_hold_o,
  input wire pc_load_o,
  input wire [14:0] pc_value_o,
  input wire vector_jump_o,
  input wire stack_wr_o,
  input wire stack_rd_o,
  input wire [15:0] stack_addr_o,
  input wire gie_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  push_order_a:
    assert property ($rose(stack_wr_o) |=> stack_wr_o &&
      stack_addr_o == $past(stack_addr_o) - 16'h1)
      else $error("entry push address not descending");
  entry_time_a:
    assert property ($rose(stack_wr_o) |-> cpu_hold_o [*3] ##1
      (pc_load_o && !cpu_hold_o && pc_value_o[0] == 1'b0))
      else $error("entry response not four cycles");
  entry_gie_a:
    assert property ($rose(stack_wr_o) |-> ##1 !gie_o [*3])
      else $error("global enable still set after entry");
  jump_len_a:
    assert property ($rose(vector_jump_o) |-> vector_jump_o [*3] ##1
      !vector_jump_o)
      else $error("vector jump not three cycles");
  pop_order_a:
    assert property ($rose(stack_rd_o) |=> stack_rd_o &&
      stack_addr_o == $past(stack_addr_o) + 16'h1)
      else $error("return pop address not ascending");
  return_time_a:
    assert property ($rose(stack_rd_o) |-> ##4 pc_load_o ##[1:2] gie_o)
      else $error("return timing or enable wrong");
  cli_block_a:
    assert property (instr_done_i && instr_cli_i |=> !stack_wr_o [*2])
      else $error("interrupt taken at disable");
  enable_gap_a:
    assert property (instr_done_i && (instr_sei_i || instr_return_from_handler_instr_i)
      |-> ##2 !stack_wr_o)
      else $error("interrupt taken on enable or return");
  wake_delay_a:
    assert property (cpu_hold_o && $rose(wake_ready_i) |->
      ##1 !stack_wr_o [*5] ##1 stack_wr_o)
      else $error("wake response not four extra cycles");
  boot_vec_a:
    assert property ($fell(reset_i) |-> ##[3:4] pc_load_o && pc_value_o ==
      (boot_reset_vector_fuse_i ? 15'h3800 : 15'h0000))
      else $error("reset vector wrong");
endmodule

bind cie_ctrl cie_monitor u_mon (.*);

/* testbench/cie_stack_model.sv */
`timescale 1ns/1ps
module cie_stack_model
(
  // Clock
  input wire clk_i,
  // Stack port of the controller
  input wire wr_i,
  input wire rd_i,
  input wire [15:0] addr_i,
  input wire [7:0] wdata_i,
  output logic [7:0] rdata_o = 8'h00
);
  logic [7:0] mem [0:255];
  // Data only in the cycle after a read; else inverted to expose stale use
  always @(posedge clk_i)
  begin
    if (wr_i)
      mem[addr_i[7:0]] <= wdata_i;
    rdata_o <= rd_i ? mem[addr_i[7:0]] : ~rdata_o;
  end
endmodule

/* testbench/cie_ctrl_bench.sv */
`timescale 1ns/1ps
`include "cie_consts.vh"
module cie_ctrl_bench;
  logic clk_i = 1'h0, reset_i = 1'h1, reg_wr_i = 1'h0, reg_rd_i = 1'h0;
  logic [2:0] reg_addr_i = 3'h0;
  logic [7:0] reg_wdata_i = 8'h00, src_i = 8'h00, reg_rdata_o, stack_rdata_i;
  logic instr_done_i = 1'h0, instr_cli_i = 1'h0, instr_sei_i = 1'h0;
  logic instr_return_from_handler_instr_i = 1'h0, sleeping_i = 1'h0, wake_ready_i = 1'h0;
  logic boot_reset_vector_fuse_i = 1'h0;
  logic [14:0] program_counter_i = 15'h0000, pc_value_o;
  logic cpu_hold_o, pc_load_o, vector_jump_o, stack_wr_o, stack_rd_o, gie_o;
  logic [15:0] stack_addr_o;
  logic [7:0] stack_wdata_o;
  int num_errors = 0;
  int cmp_count = 0;

  always #10 clk_i = ~clk_i;

  cie_ctrl dut (.*);
  cie_stack_model u_stack (.clk_i(clk_i), .wr_i(stack_wr_o),
    .rd_i(stack_rd_o), .addr_i(stack_addr_o), .wdata_i(stack_wdata_o),
    .rdata_o(stack_rdata_i));

  task test_done;
    if (num_errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'h1;
    @(posedge clk_i);
    reg_wr_i <= 1'h0;
    @(posedge clk_i);
  endtask

  task rd(input logic [2:0] a, input logic [7:0] e);
    reg_addr_i <= a;
    reg_rd_i <= 1'h1;
    @(posedge clk_i);
    reg_rd_i <= 1'h0;
    #1 chk(reg_rdata_o, e);
    @(posedge clk_i);
  endtask

  // One completed instruction: disable, enable, return flags and next pc
  task ins(input logic c, input logic s, input logic r, input logic [14:0] pc);
    {instr_done_i, instr_cli_i, instr_sei_i, instr_return_from_handler_instr_i} <= {1'h1, c, s, r};
    program_counter_i <= pc;
    @(posedge clk_i);
    {instr_done_i, instr_cli_i, instr_sei_i, instr_return_from_handler_instr_i} <= 4'h0;
    @(posedge clk_i);
  endtask

  task pulse(input logic [7:0] m);
    src_i <= m;
    @(posedge clk_i);
    src_i <= 8'h00;
    @(posedge clk_i);
  endtask

  task wait_load(input logic [14:0] e);
    for (int n = 0; n < 40; n++)
    begin
      @(posedge clk_i);
      #1;
      if (pc_load_o === 1'h1)
      begin
        chk(pc_value_o, e);
        // Let a vector jump finish before the next instruction
        repeat (`CIE_JUMP_CYC) @(posedge clk_i);
        return;
      end
    end
    num_errors++;
    test_done;
  endtask

  initial
  begin
    repeat (20) @(posedge clk_i);
    reset_i <= 1'h0;
    wait_load(`CIE_RESET_VEC);
    boot_reset_vector_fuse_i <= 1'h1;
    reset_i <= 1'h1;
    repeat (20) @(posedge clk_i);
    reset_i <= 1'h0;
    wait_load(`CIE_BOOT_START);
    rd(3'h7, 8'h00);
    rd(`CIE_ADDR_STATUS, `CIE_STATUS_RST);
    wr(`CIE_ADDR_SPL, 8'hf0);
    wr(`CIE_ADDR_ENABLE, 8'hff);
    pulse(8'h0e);
    rd(`CIE_ADDR_FLAGS, 8'h0e);
    wr(`CIE_ADDR_FLAGS, 8'h08);
    rd(`CIE_ADDR_FLAGS, 8'h06);
    ins(1'h0, 1'h1, 1'h0, 15'h0100);
    ins(1'h1, 1'h0, 1'h0, 15'h0101);
    rd(`CIE_ADDR_SPL, 8'hf0);
    ins(1'h0, 1'h1, 1'h0, 15'h0102);
    ins(1'h0, 1'h0, 1'h0, 15'h1234);
    wait_load(15'h0004);
    rd(`CIE_ADDR_FLAGS, 8'h04);
    rd(`CIE_ADDR_STATUS, 8'h00);
    rd(`CIE_ADDR_SPL, 8'hee);
    chk(u_stack.mem[8'hf0], 8'h34);
    chk(u_stack.mem[8'hef], 8'h12);
    // Handler reopens interrupts so the waiting flag can nest
    wr(`CIE_ADDR_STATUS, 8'h80);
    ins(1'h0, 1'h0, 1'h0, 15'h0400);
    wait_load(15'h0006);
    rd(`CIE_ADDR_SPL, 8'hec);
    src_i <= 8'h20;
    ins(1'h0, 1'h0, 1'h1, 15'h0000);
    wait_load(15'h0400);
    rd(`CIE_ADDR_SPL, 8'hee);
    rd(`CIE_ADDR_STATUS, 8'h80);
    ins(1'h0, 1'h0, 1'h1, 15'h0000);
    wait_load(15'h1234);
    rd(`CIE_ADDR_SPL, 8'hf0);
    ins(1'h0, 1'h0, 1'h0, 15'h2000);
    wait_load(15'h000c);
    // Level 5 drops and level 4 flashes while the handler blocks all
    pulse(8'h10);
    ins(1'h0, 1'h0, 1'h1, 15'h0000);
    wait_load(15'h2000);
    ins(1'h0, 1'h0, 1'h0, 15'h2001);
    repeat (2) @(posedge clk_i);
    rd(`CIE_ADDR_SPL, 8'hf0);
    // Flag event while asleep; start-up delay ends at once
    sleeping_i <= 1'h1;
    pulse(8'h01);
    sleeping_i <= 1'h0;
    wake_ready_i <= 1'h1;
    repeat (8) @(posedge clk_i);
    #1 chk(pc_load_o, 1'h0);
    wait_load(15'h0002);
    wake_ready_i <= 1'h0;
    rd(`CIE_ADDR_FLAGS, 8'h00);
    chk(u_stack.mem[8'hf0], 8'h01);
    chk(u_stack.mem[8'hef], 8'h20);
    test_done;
  end
endmodule
